// [rtl/mcr_pkg.sv]
// Package for the receive mode command record writer
package mcr_pkg;
  // ----------------------------------------
  // Record layout
  // ----------------------------------------
  localparam int          RAM_AW        = 13;
  localparam logic [1:0]  OFS_INFO      = 2'h0;  // Info word offset
  localparam logic [1:0]  OFS_TTAG      = 2'h1;  // Time tag offset
  localparam logic [1:0]  OFS_DATA      = 2'h2;  // Mode data offset
  localparam logic [4:0]  MC_DATA_FIRST = 5'h10; // First code with data
  localparam logic [4:0]  MC_UNDEF_16   = 5'h10;
  localparam logic [4:0]  MC_UNDEF_18   = 5'h12;
  localparam logic [4:0]  MC_UNDEF_19   = 5'h13;
  // ----------------------------------------
  // Message information word bit positions
  // ----------------------------------------
  localparam int BIT_INVALID_WORD = 14;
  localparam int BIT_GAP_OR_BROADCAST_FLAG    = 13;
  localparam int BIT_WORD_COUNT   = 12;
  localparam int BIT_SYNC_TYPE    = 11;
  localparam int BIT_MSG_ERROR    = 10;
  localparam int BIT_WAS_BUSY     = 9;
  localparam int BIT_ILLEGAL      = 8;
  localparam int BIT_BUS_SEL      = 5;
  localparam logic [15:0] INFO_RESET = 16'h0000;
  // Writer states
  typedef enum logic [1:0] {MCR_IDLE, MCR_INFO, MCR_TTAG, MCR_DATA} mcr_state_e;
endpackage

// [rtl/mcr_writer.sv]
// Receive mode command record writer: forms the info word, writes record
`timescale 1ns/10ps
// Notes on behaviour
// [RULE1] Codes 0-15 store info and time tag
// [RULE2] Codes 16-31 store three-word record
// [RULE3] Info word at data pointer
// [RULE4] Time tag at pointer plus one
// [RULE5] Mode data at pointer plus two
// [RULE6] Pointer marks record start, not data
// [RULE7] Record written only after message completes
// [RULE8] Received mode data also stored
// [RULE9] Codes 16,18,19 answered if legal and permitted
// [RULE10] Codes 0-15 answered only if both bits zero
// [RULE11] Bit 14 flags Manchester or parity error
// [RULE12] Bit 13 gap error or broadcast
// [RULE13] Bit 12 flags missing or extra word
// [RULE14] Bit 11 flags wrong sync type
// [RULE15] Bit 10 summarises bits 11 to 14, bit 13 only when it flags gap
// [RULE16] Bit 9 set when answered busy
// [RULE17] Bit 8 set when command illegalized
// [RULE18] Host loads illegalization only when intended
// [RULE19] Bit 5 zero bus A, one bus B
// [RULE20] Mode code placed in bits 4-0
// [RULE21] Bits 15, 7, 6 written zero
module mcr_writer
  import mcr_pkg::*;
(
  input  wire logic                      clk,            // 20 MHz clock
  input  wire logic                      reset_n,        // Async reset, low
  input  wire logic                      msg_done,       // Message complete
  input  wire logic [4:0]                mode_code_field,// Code from command
  input  wire logic [mcr_pkg::RAM_AW-1:0] data_pointer,  // Descriptor pointer
  input  wire logic [15:0]               mode_data,      // Received data word
  input  wire logic [15:0]               time_tag,       // Time tag value
  input  wire logic                      bus_b,          // Message on bus B
  input  wire logic                      invalid_word_error, // Manch/parity
  input  wire logic                      gap_seen,       // Gap fault seen
  input  wire logic                      broadcast,      // Broadcast message
  input  wire logic                      ext_cfg_bcast,  // Ext cfg bit 3
  input  wire logic                      word_count_error, // Missing/extra
  input  wire logic                      sync_type_error,// Cmd sync on data
  input  wire logic                      global_busy,    // Global busy bit
  input  wire logic                      descriptor_force_busy, // Force busy
  input  wire logic                      illegal_bit,    // Table bit is one
  input  wire logic                      undefined_mode_code_invalid, // Cfg
  output logic                           answer_ok,      // Respond in form
  output logic                           ram_we,         // RAM write strobe
  output logic [mcr_pkg::RAM_AW-1:0]     ram_addr,       // RAM address
  output logic [15:0]                    ram_wdata,      // RAM write data
  output logic                           rec_busy        // Record in flight
);
  import mcr_pkg::*;

  typedef struct packed {
    mcr_state_e          st;
    logic [RAM_AW-1:0]   ptr;
    logic [15:0]         info;
    logic [15:0]         ttag;
    logic [15:0]         mdata;
    logic                has_data;
    logic                ok;
    logic                we;
    logic [RAM_AW-1:0]   addr;
    logic [15:0]         wdata;
    logic                busy;
  } mcr_s;

  mcr_s r;
  mcr_s next_r;
  logic [15:0] info_w;
  logic        with_data;
  logic        undef_data;
  logic        err_any;

  // ----------------------------------------
  // Information word assembly
  // ----------------------------------------
  // Flags are sampled at completion so late errors are not missed
  always_comb begin
    with_data  = mode_code_field >= MC_DATA_FIRST;          // RULE1 RULE2
    undef_data = mode_code_field == MC_UNDEF_16 ||
                 mode_code_field == MC_UNDEF_18 ||
                 mode_code_field == MC_UNDEF_19;
    err_any    = invalid_word_error | word_count_error |
                 sync_type_error |
                 (gap_seen & ~ext_cfg_bcast);                // RULE15
    info_w = INFO_RESET;                                     // RULE21
    info_w[BIT_INVALID_WORD] = invalid_word_error;           // RULE11
    info_w[BIT_GAP_OR_BROADCAST_FLAG]    = ext_cfg_bcast ? broadcast
                                             : gap_seen;     // RULE12
    info_w[BIT_WORD_COUNT]   = word_count_error;             // RULE13
    info_w[BIT_SYNC_TYPE]    = sync_type_error;              // RULE14
    info_w[BIT_MSG_ERROR]    = err_any;                      // RULE15
    info_w[BIT_WAS_BUSY]     = global_busy |
                               descriptor_force_busy;        // RULE16
    info_w[BIT_ILLEGAL]      = illegal_bit;                  // RULE17
    info_w[BIT_BUS_SEL]      = bus_b;                        // RULE19
    info_w[4:0]              = mode_code_field;              // RULE20
  end

  // ----------------------------------------
  // Record write sequencer
  // ----------------------------------------
  // One word per cycle; a new completion during a record is ignored
  always_comb begin
    next_r    = r;
    next_r.we = 1'b0;
    case (r.st)
      MCR_IDLE: begin
        if (msg_done) begin                                  // RULE7
          // Held from completion: later input changes must not disturb it
          if (!with_data)
            next_r.ok = ~illegal_bit & ~undefined_mode_code_invalid; // RULE10
          else if (undef_data)
            next_r.ok = ~illegal_bit & ~undefined_mode_code_invalid; // RULE9
          else
            next_r.ok = ~illegal_bit;
          next_r.ptr      = data_pointer;                    // RULE6
          next_r.info     = info_w;
          next_r.ttag     = time_tag;
          next_r.mdata    = mode_data;                       // RULE8
          next_r.has_data = with_data;
          next_r.st       = MCR_INFO;
        end
      end
      MCR_INFO: begin
        next_r.we    = 1'b1;
        next_r.addr  = r.ptr + RAM_AW'(OFS_INFO);            // RULE3
        next_r.wdata = r.info;
        next_r.st    = MCR_TTAG;
      end
      MCR_TTAG: begin
        next_r.we    = 1'b1;
        next_r.addr  = r.ptr + RAM_AW'(OFS_TTAG);            // RULE4
        next_r.wdata = r.ttag;
        next_r.st    = r.has_data ? MCR_DATA : MCR_IDLE;     // RULE1
      end
      MCR_DATA: begin
        next_r.we    = 1'b1;
        next_r.addr  = r.ptr + RAM_AW'(OFS_DATA);            // RULE5
        next_r.wdata = r.mdata;
        next_r.st    = MCR_IDLE;                             // RULE2
      end
      default: next_r.st = MCR_IDLE;
    endcase
    // Busy is registered so the output comes straight from a flip-flop
    next_r.busy = next_r.st != MCR_IDLE;
  end

  // State register
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign answer_ok = r.ok;
  assign ram_we    = r.we;
  assign ram_addr  = r.addr;
  assign ram_wdata = r.wdata;
  assign rec_busy  = r.busy;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_info_at_ptr: assert property (@(posedge clk) disable iff (!reset_n) // RULE3
    (r.st == MCR_IDLE && msg_done) |-> ##2 (ram_we &&
      ram_addr == $past(data_pointer, 2)))
    else $error("info word not at pointer");
  a_ttag_next: assert property (@(posedge clk) disable iff (!reset_n) // RULE4
    (r.st == MCR_IDLE && msg_done) |-> ##3 (ram_we &&
      ram_addr == $past(data_pointer, 3) + 1'b1))
    else $error("time tag not at pointer plus one");
  a_data_plus2: assert property (@(posedge clk) disable iff (!reset_n) // RULE5
    (r.st == MCR_IDLE && msg_done && mode_code_field[4]) |-> ##4
      (ram_we && ram_addr == $past(data_pointer, 4) + 2'h2))
    else $error("mode data not at pointer plus two");
  a_two_words: assert property (@(posedge clk) disable iff (!reset_n) // RULE1
    (r.st == MCR_IDLE && msg_done && !mode_code_field[4]) |-> ##4 !ram_we)
    else $error("short record wrote a third word");
  a_idle_no_write: assert property (@(posedge clk) disable iff (!reset_n) // RULE7
    (r.st == MCR_IDLE && !$past(rec_busy)) |-> !ram_we)
    else $error("write outside record");
  a_message_error_summary_sum: assert property (@(posedge clk) disable iff (!reset_n) // RULE15
    ram_we && r.st == MCR_TTAG |->
      ram_wdata[BIT_MSG_ERROR] == (|ram_wdata[14:11] &&
      !(ram_wdata[13] && !ram_wdata[12] && !ram_wdata[11] &&
        !ram_wdata[14] && $past(ext_cfg_bcast, 2))))
    else $error("summary error mismatch");
  a_zero_bits: assert property (@(posedge clk) disable iff (!reset_n) // RULE21
    ram_we && r.st == MCR_TTAG |-> ram_wdata[15] == 1'b0 &&
      ram_wdata[7:6] == 2'h0)
    else $error("unused bits not zero");
  a_code_field: assert property (@(posedge clk) disable iff (!reset_n) // RULE20
    (r.st == MCR_IDLE && msg_done) |-> ##2
      ram_wdata[4:0] == $past(mode_code_field, 2))
    else $error("mode code field wrong");
  a_busy_flag: assert property (@(posedge clk) disable iff (!reset_n) // RULE16
    (r.st == MCR_IDLE && msg_done && global_busy) |-> ##2
      ram_wdata[BIT_WAS_BUSY])
    else $error("busy flag missing");

  // ----------------------------------------
  // Flag and record content checks
  // ----------------------------------------
  // Bit 14 copies the word error seen at completion
  a_invalid_bit: assert property (@(posedge clk) // RULE11
    disable iff (!reset_n)
    (r.st == MCR_IDLE && msg_done) |-> ##2
      ram_wdata[BIT_INVALID_WORD] == $past(invalid_word_error, 2))
    else $error("word error flag wrong");

  // Bit 13 follows the configured meaning
  a_gap_or_broadcast_flag: assert property (@(posedge clk) // RULE12
    disable iff (!reset_n)
    (r.st == MCR_IDLE && msg_done) |-> ##2
      ram_wdata[BIT_GAP_OR_BROADCAST_FLAG] == ($past(ext_cfg_bcast, 2) ?
        $past(broadcast, 2) : $past(gap_seen, 2)))
    else $error("gap or broadcast flag wrong");

  // Bit 12 copies the word count error
  a_wct_bit: assert property (@(posedge clk) // RULE13
    disable iff (!reset_n)
    (r.st == MCR_IDLE && msg_done) |-> ##2
      ram_wdata[BIT_WORD_COUNT] == $past(word_count_error, 2))
    else $error("word count flag wrong");

  // Bit 11 copies the sync type error
  a_sync_bit: assert property (@(posedge clk) // RULE14
    disable iff (!reset_n)
    (r.st == MCR_IDLE && msg_done) |-> ##2
      ram_wdata[BIT_SYNC_TYPE] == $past(sync_type_error, 2))
    else $error("sync type flag wrong");

  // The descriptor busy request alone must also mark busy
  a_force_busy: assert property (@(posedge clk) // RULE16
    disable iff (!reset_n)
    (r.st == MCR_IDLE && msg_done && descriptor_force_busy) |-> ##2
      ram_wdata[BIT_WAS_BUSY])
    else $error("forced busy flag missing");

  // Bit 8 copies the table bit
  a_illegal_bit: assert property (@(posedge clk) // RULE17
    disable iff (!reset_n)
    (r.st == MCR_IDLE && msg_done) |-> ##2
      ram_wdata[BIT_ILLEGAL] == $past(illegal_bit, 2))
    else $error("illegal flag wrong");

  // Bit 5 names the bus the message came on
  a_bus_sel: assert property (@(posedge clk) // RULE19
    disable iff (!reset_n)
    (r.st == MCR_IDLE && msg_done) |-> ##2
      ram_wdata[BIT_BUS_SEL] == $past(bus_b, 2))
    else $error("bus select bit wrong");

  // Second word carries the time tag captured at completion
  a_ttag_word: assert property (@(posedge clk) // RULE4
    disable iff (!reset_n)
    (r.st == MCR_IDLE && msg_done) |-> ##3
      ram_wdata == $past(time_tag, 3))
    else $error("time tag word wrong");

  // Third word carries the received mode data
  a_data_word: assert property (@(posedge clk) // RULE8
    disable iff (!reset_n)
    (r.st == MCR_IDLE && msg_done && mode_code_field[4]) |-> ##4
      ram_wdata == $past(mode_data, 4))
    else $error("mode data word wrong");

  // ----------------------------------------
  // Answer and busy checks
  // ----------------------------------------
  // Codes without data answer only when legal and not declared invalid
  a_answer_short: assert property (@(posedge clk) // RULE10
    disable iff (!reset_n)
    (r.st == MCR_IDLE && msg_done && !mode_code_field[4]) |=>
      answer_ok == (!$past(illegal_bit) &&
                    !$past(undefined_mode_code_invalid)))
    else $error("answer for short code wrong");

  // Undefined codes with data need the same two conditions
  a_answer_undef: assert property (@(posedge clk) // RULE9
    disable iff (!reset_n)
    (r.st == MCR_IDLE && msg_done && (mode_code_field == MC_UNDEF_16 ||
      mode_code_field == MC_UNDEF_18 || mode_code_field == MC_UNDEF_19))
      |=> answer_ok == (!$past(illegal_bit) &&
                        !$past(undefined_mode_code_invalid)))
    else $error("answer for undefined code wrong");

  // Defined codes with data depend on the table bit only
  a_answer_defined: assert property (@(posedge clk) // RULE9
    disable iff (!reset_n)
    (r.st == MCR_IDLE && msg_done && mode_code_field[4] &&
      mode_code_field != MC_UNDEF_16 && mode_code_field != MC_UNDEF_18 &&
      mode_code_field != MC_UNDEF_19) |=> answer_ok == !$past(illegal_bit))
    else $error("answer for defined code wrong");

  // Busy rises on the edge after a taken completion
  a_busy_rise: assert property (@(posedge clk) // RULE7
    disable iff (!reset_n)
    (r.st == MCR_IDLE && msg_done) |=> rec_busy)
    else $error("busy not raised");

  // A short record frees the writer after its second word
  a_short_done: assert property (@(posedge clk) // RULE1
    disable iff (!reset_n)
    (r.st == MCR_IDLE && msg_done && !mode_code_field[4]) |-> ##3
      !rec_busy)
    else $error("short record still busy");

  // A long record frees the writer after its third word
  a_long_done: assert property (@(posedge clk) // RULE2
    disable iff (!reset_n)
    (r.st == MCR_IDLE && msg_done && mode_code_field[4]) |-> ##4
      !rec_busy)
    else $error("long record still busy");
endmodule

// [sim/mcr_bc_model.sv]
// Bus controller model: hands one completed mode command to the writer
`timescale 1ns/10ps
module mcr_bc_model (
  input  wire logic        clk,  // System clock
  output logic             done, // Message complete pulse
  output logic [4:0]       mc,   // Mode code
  output logic [12:0]      ptr,  // Data pointer
  output logic [15:0]      dat,  // Mode data word
  output logic [15:0]      tt,   // Time tag
  output logic [9:0]       fl    // Flags, bus select in bit 0
);
  // ----------------------------------------
  // Command issue
  // ----------------------------------------
  initial begin
    {done, mc, ptr, dat, tt, fl} = '0;
  end
  // Illegal bit in fl[9] is set when a test means it, and flips with the other lines on release
  task automatic issue(input logic [4:0] c, input logic [12:0] p,
                       input logic [9:0] f);
    @(posedge clk);
    #1;
    {mc, ptr, fl} = {c, p, f};
    tt = {3'h0, p} ^ 16'hA5C3;
    dat = ~tt;
    done = 1'b1;
    @(posedge clk);
    #1;
    done = 1'b0;
    // Released lines flip, so a late sample shows up as a mismatch
    {mc, ptr, tt, dat, fl} = ~{mc, ptr, tt, dat, fl};
  endtask
endmodule

// [sim/mode_cmd_receive_record_writer_tb.sv]
// Testbench for the receive mode command record writer
`timescale 1ns/10ps
module mode_cmd_receive_record_writer_tb;
  logic clk = 0, reset_n = 0, umc = 0, done, ok, we, busy;
  logic [4:0] mc;
  logic [12:0] ptr, wa [4], addr;
  logic [15:0] dat, tt, wd [4], wdata;
  logic [9:0] fl;
  int err_count = 0, checks_done = 0, n = 0, cyc = 0;
  // ----------------------------------------
  // Clock, model, design and write capture
  // ----------------------------------------
  always #25 clk = ~clk;
  mcr_bc_model u_mcr_bc_model (.clk(clk), .done(done), .mc(mc),
    .ptr(ptr), .dat(dat), .tt(tt), .fl(fl));
  mcr_writer u_mcr_writer (.clk(clk), .reset_n(reset_n), .msg_done(done),
    .mode_code_field(mc), .data_pointer(ptr), .mode_data(dat),
    .time_tag(tt), .bus_b(fl[0]), .invalid_word_error(fl[1]),
    .gap_seen(fl[2]), .broadcast(fl[3]), .ext_cfg_bcast(fl[4]),
    .word_count_error(fl[5]), .sync_type_error(fl[6]),
    .global_busy(fl[7]), .descriptor_force_busy(fl[8]),
    .illegal_bit(fl[9]), .undefined_mode_code_invalid(umc),
    .answer_ok(ok), .ram_we(we), .ram_addr(addr), .ram_wdata(wdata),
    .rec_busy(busy));
  // Log the first four strobes; a count past four is still counted
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      err_count++;
      summarize();
    end
    if (we === 1'b1) begin
      if (n < 4) begin
        wa[n] <= addr;
        wd[n] <= wdata;
      end
      n <= n + 1;
    end
  end
  task automatic chk(input string s, input logic [15:0] e, g);
    checks_done++;
    if (e !== g) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", s, e, g);
    end
  endtask
  // One command, then the answer and every stored word are judged
  task automatic rec(input logic [4:0] c, input logic [12:0] p,
                     input logic [9:0] f, input logic u);
    logic [15:0] inf, t;
    logic m, a;
    umc = u;
    n = 0;
    m = f[1] | f[5] | f[6] | (f[2] & ~f[4]);
    inf = {1'b0, f[1], f[4] ? f[3] : f[2], f[5], f[6], m, f[7] | f[8],
           f[9], 2'b00, f[0], c};
    a = ~f[9] & ((~c[4] | c == 5'h10 | c == 5'h12 | c == 5'h13) ? ~u : 1);
    t = {3'h0, p} ^ 16'hA5C3;
    u_mcr_bc_model.issue(c, p, f);
    @(posedge clk);
    #1;
    chk("answer_ok", {15'h0, a}, {15'h0, ok});
    chk("early writes", 0, 16'(n));
    chk("rec_busy", 16'h0001, {15'h0, busy});
    repeat (5) @(posedge clk);
    #1;
    chk("write count", c[4] ? 3 : 2, 16'(n));
    chk("rec_busy end", 16'h0000, {15'h0, busy});
    chk("info addr", {3'h0, p}, {3'h0, wa[0]});
    chk("info word", inf, wd[0]);
    chk("ttag addr", {3'h0, p + 13'h1}, {3'h0, wa[1]});
    chk("ttag word", t, wd[1]);
    if (c[4]) begin
      chk("data addr", {3'h0, p + 13'h2}, {3'h0, wa[2]});
      chk("data word", ~t, wd[2]);
    end
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_no_data();
    rec(5'h05, 13'h1500, 10'h000, 0);
    rec(5'h0F, 13'h0000, 10'h001, 1);
  endtask
  task automatic t_with_data();
    rec(5'h1F, 13'h1FFD, 10'h001, 1);
    rec(5'h10, 13'h1500, 10'h000, 0);
    rec(5'h12, 13'h0200, 10'h000, 1);
    rec(5'h13, 13'h0300, 10'h200, 0);
    rec(5'h11, 13'h0400, 10'h000, 1);
  endtask
  task automatic t_flags();
    for (int i = 1; i < 10; i++) begin
      rec(5'h1A, 13'h0100, 10'h001 << i, 0);
    end
    rec(5'h16, 13'h0700, 10'h018, 0);
    rec(5'h16, 13'h0700, 10'h014, 0);
  endtask
  task automatic summarize();
    if (err_count == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge clk);
    #1;
    reset_n = 1;
    t_no_data();
    t_with_data();
    t_flags();
    summarize();
  end
endmodule
